// ### shared/eeic_pkg.sv
/*
 * Constants, register layout and state types for the edge event input
 * control block.
 * Assumes a single pclk domain and an APB master with 32-bit data.
 */
package eeic_pkg;

   localparam int unsigned EEIC_AW     = 12;
   localparam int unsigned EEIC_DW     = 32;
   localparam int unsigned EEIC_SEL_W  = 4;
   localparam int unsigned EEIC_PINS   = 2;

   // Control register word address
   localparam logic [EEIC_AW-1:0] EEIC_CTRL_ADDR = 12'h000;

   // Byte lanes holding the control register
   localparam int unsigned EEIC_LANE_LO = 0;
   localparam int unsigned EEIC_LANE_HI = 1;

   // Index of each pin inside the synchroniser vectors
   localparam int unsigned EEIC_PIN1 = 0;
   localparam int unsigned EEIC_PIN2 = 1;

   // First channel source codes
   localparam logic [EEIC_SEL_W-1:0] EEIC_A_TIMER1 = 4'h0;
   localparam logic [EEIC_SEL_W-1:0] EEIC_A_OC1    = 4'h1;
   localparam logic [EEIC_SEL_W-1:0] EEIC_A_PIN2   = 4'h2;
   localparam logic [EEIC_SEL_W-1:0] EEIC_A_PIN1   = 4'h3;

   // Second channel source codes
   localparam logic [EEIC_SEL_W-1:0] EEIC_B_OC1    = 4'h1;
   localparam logic [EEIC_SEL_W-1:0] EEIC_B_PIN1   = 4'h2;
   localparam logic [EEIC_SEL_W-1:0] EEIC_B_COMPARATOR_2   = 4'h4;
   localparam logic [EEIC_SEL_W-1:0] EEIC_B_RSVD   = 4'hF;

   localparam logic [EEIC_DW-1:0] EEIC_RDATA_ZERO = 32'h0000_0000;
   localparam logic [15:0]        EEIC_HI_ZERO    = 16'h0000;

   // Register layout as software sees it, bit 15 down to bit 0
   typedef struct packed {
      logic                  mode_a;
      logic                  pol_a;
      logic [EEIC_SEL_W-1:0] sel_a;
      logic                  stat_b;
      logic                  stat_a;
      logic                  mode_b;
      logic                  pol_b;
      logic [EEIC_SEL_W-1:0] sel_b;
      logic [1:0]            rsvd;
   } eeic_ctrl_t;

   // Writable configuration held by the block
   typedef struct packed {
      logic                  mode_a;
      logic                  pol_a;
      logic [EEIC_SEL_W-1:0] sel_a;
      logic                  mode_b;
      logic                  pol_b;
      logic [EEIC_SEL_W-1:0] sel_b;
   } eeic_cfg_t;

   localparam eeic_cfg_t EEIC_CFG_RESET = '0;

   // On-chip event sources, already in the pclk domain
   typedef struct packed {
      logic timer_1_event;
      logic output_compare_1;
      logic comparator_2;
   } eeic_evt_t;

   typedef struct packed {
      eeic_cfg_t            cfg;
      logic [EEIC_PINS-1:0] pin_s1;
      logic [EEIC_PINS-1:0] pin_s2;
      logic [EEIC_DW-1:0]   prdata;
   } eeic_main_st_t;

   typedef struct packed {
      logic prev;
      logic flag;
   } eeic_chan_st_t;

endpackage

// ### logic/eeic_edge_chan.sv
/*
 * One edge channel: qualifies the selected source by sense mode and
 * polarity and keeps the sticky occurred flag.
 * Assumes src is already synchronous to pclk.
 */
module eeic_edge_chan
   import eeic_pkg::*;
(
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic src,
   input  wire logic src_valid,
   input  wire logic sense_edge,
   input  wire logic polarity,
   input  wire logic sw_wr,
   input  wire logic sw_val,
   output logic      hit,
   output logic      flag
);

   eeic_chan_st_t st_r;
   eeic_chan_st_t st_nxt;

   always_comb begin
      st_nxt      = st_r;
      st_nxt.prev = src;
      if (sense_edge) begin
         hit = src_valid && (src == polarity) && (src != st_r.prev);
      end else begin
         hit = src_valid && (src == polarity);
      end
      if (sw_wr) begin
         st_nxt.flag = sw_val;
      end
      // Set beats a same-cycle software clear
      if (hit) begin
         st_nxt.flag = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign flag = st_r.flag;

   hit_sets_flag_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      hit |=> flag)
      else $error("flag not set after qualifying event");

   flag_sticky_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      (flag && !(sw_wr && !sw_val)) |=> flag)
      else $error("flag dropped without software clear");

   edge_needs_change_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      (hit && sense_edge) |-> (src != $past(src)))
      else $error("edge mode hit without a transition");

endmodule

// ### logic/eeic_edge_ctrl.sv
/*
 * Edge event input control: APB register, source routing for both edge
 * channels, pin synchronisers and the occurred flags.
 * Assumes a zero-wait APB master on pclk and on-chip sources on pclk.
 */
module eeic_edge_ctrl
   import eeic_pkg::*;
(
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [EEIC_AW-1:0]   paddr,
   input  wire logic [EEIC_DW-1:0]   pwdata,
   input  wire logic [3:0]           pstrb,
   output logic      [EEIC_DW-1:0]   prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire eeic_evt_t            evt_in,
   input  wire logic                 edge_input_pin_1,
   input  wire logic                 edge_input_pin_2,
   output logic                      edge_a_occurred_flag,
   output logic                      edge_b_occurred_flag
);

   eeic_main_st_t st_r;
   eeic_main_st_t st_nxt;

   logic       setup_ph;
   logic       access_ph;
   logic       addr_hit;
   logic       wr_lo;
   logic       wr_hi;
   eeic_ctrl_t wr_word;
   eeic_ctrl_t rd_view;
   logic       pin1_sync;
   logic       pin2_sync;
   logic       src_a;
   logic       src_a_valid;
   logic       src_b;
   logic       src_b_valid;
   logic       hit_a;
   logic       hit_b;
   logic       flag_a;
   logic       flag_b;

   assign setup_ph  = psel && !penable;
   assign access_ph = psel && penable;
   assign addr_hit  = (paddr == EEIC_CTRL_ADDR);
   assign wr_lo     = access_ph && pwrite && addr_hit && pstrb[EEIC_LANE_LO];
   assign wr_hi     = access_ph && pwrite && addr_hit && pstrb[EEIC_LANE_HI];
   assign wr_word   = eeic_ctrl_t'(pwdata[15:0]);

   // Zero-wait slave; unmapped word answers with an error
   assign pready  = 1'b1;
   assign pslverr = access_ph && !addr_hit;
   assign prdata  = st_r.prdata;

   // Only the second stage is looked at by any logic
   assign pin1_sync = st_r.pin_s2[EEIC_PIN1];
   assign pin2_sync = st_r.pin_s2[EEIC_PIN2];

   // Readback of the whole control word; low two bits read zero
   always_comb begin
      rd_view        = '0;
      rd_view.mode_a = st_r.cfg.mode_a;
      rd_view.pol_a  = st_r.cfg.pol_a;
      rd_view.sel_a  = st_r.cfg.sel_a;
      rd_view.stat_b = flag_b;
      rd_view.stat_a = flag_a;
      rd_view.mode_b = st_r.cfg.mode_b;
      rd_view.pol_b  = st_r.cfg.pol_b;
      rd_view.sel_b  = st_r.cfg.sel_b;
   end

   // First channel routing; reserved codes never produce an event
   always_comb begin
      src_a       = 1'b0;
      src_a_valid = 1'b1;
      unique case (st_r.cfg.sel_a)
         EEIC_A_TIMER1: begin
            src_a = evt_in.timer_1_event;
         end
         EEIC_A_OC1: begin
            src_a = evt_in.output_compare_1;
         end
         EEIC_A_PIN2: begin
            src_a = pin2_sync;
         end
         EEIC_A_PIN1: begin
            src_a = pin1_sync;
         end
         default: begin
            src_a_valid = 1'b0;
         end
      endcase
   end

   // Second channel routing; reserved codes never produce an event
   always_comb begin
      src_b       = 1'b0;
      src_b_valid = 1'b1;
      unique case (st_r.cfg.sel_b)
         EEIC_B_OC1: begin
            src_b = evt_in.output_compare_1;
         end
         EEIC_B_PIN1: begin
            src_b = pin1_sync;
         end
         EEIC_B_COMPARATOR_2: begin
            src_b = evt_in.comparator_2;
         end
         default: begin
            src_b_valid = 1'b0;
         end
      endcase
   end

   always_comb begin
      st_nxt        = st_r;
      st_nxt.pin_s1 = {edge_input_pin_2, edge_input_pin_1};
      st_nxt.pin_s2 = st_r.pin_s1;
      // Read data is caught in the setup phase so prdata is a flop
      if (setup_ph) begin
         if (addr_hit && !pwrite) begin
            st_nxt.prdata = {EEIC_HI_ZERO, rd_view};
         end else begin
            st_nxt.prdata = EEIC_RDATA_ZERO;
         end
      end
      if (wr_hi) begin
         st_nxt.cfg.mode_a = wr_word.mode_a;
         st_nxt.cfg.pol_a  = wr_word.pol_a;
         st_nxt.cfg.sel_a  = wr_word.sel_a;
      end
      if (wr_lo) begin
         st_nxt.cfg.mode_b = wr_word.mode_b;
         st_nxt.cfg.pol_b  = wr_word.pol_b;
         st_nxt.cfg.sel_b  = wr_word.sel_b;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r        <= '0;
         st_r.cfg    <= EEIC_CFG_RESET;
         st_r.prdata <= EEIC_RDATA_ZERO;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Writes to the status bits land in the high byte lane
   eeic_edge_chan u_chan_a (
      .pclk       (pclk),
      .presetn    (presetn),
      .src        (src_a),
      .src_valid  (src_a_valid),
      .sense_edge (st_r.cfg.mode_a),
      .polarity   (st_r.cfg.pol_a),
      .sw_wr      (wr_hi),
      .sw_val     (wr_word.stat_a),
      .hit        (hit_a),
      .flag       (flag_a)
   );

   eeic_edge_chan u_chan_b (
      .pclk       (pclk),
      .presetn    (presetn),
      .src        (src_b),
      .src_valid  (src_b_valid),
      .sense_edge (st_r.cfg.mode_b),
      .polarity   (st_r.cfg.pol_b),
      .sw_wr      (wr_hi),
      .sw_val     (wr_word.stat_b),
      .hit        (hit_b),
      .flag       (flag_b)
   );

   assign edge_a_occurred_flag = flag_a;
   assign edge_b_occurred_flag = flag_b;

   flag_b_set_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      hit_b |=> (edge_b_occurred_flag && rd_view.stat_b))
      else $error("second flag missed its event");

   flag_b_write_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_hi && !hit_b) |=> (flag_b == $past(wr_word.stat_b)))
      else $error("second flag ignored software write");

   flag_a_set_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      hit_a |=> (edge_a_occurred_flag && rd_view.stat_a))
      else $error("first flag missed its event");

   flag_a_write_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_hi && !hit_a) |=> (flag_a == $past(wr_word.stat_a)))
      else $error("first flag ignored software write");

   level_mode_b_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      (!st_r.cfg.mode_b && src_b_valid && src_b == st_r.cfg.pol_b)
      |-> hit_b)
      else $error("level mode missed an active level");

   edge_mode_b_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      (st_r.cfg.mode_b && $stable(st_r.cfg.sel_b) && $stable(src_b))
      |-> !hit_b)
      else $error("edge mode fired without a transition");

   polarity_b_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      hit_b |-> (src_b == st_r.cfg.pol_b))
      else $error("second channel fired on wrong polarity");

   route_b_pin_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      (st_r.cfg.sel_b == EEIC_B_PIN1)
      |-> (src_b == $past(edge_input_pin_1, 2) && src_b_valid))
      else $error("second channel pin route wrong");

   route_b_rsvd_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      (st_r.cfg.sel_b == EEIC_B_RSVD) |-> !hit_b)
      else $error("reserved source produced an event");

   polarity_a_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      hit_a |-> (src_a == st_r.cfg.pol_a))
      else $error("first channel fired on wrong polarity");

   route_a_pin_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      (st_r.cfg.sel_a == EEIC_A_PIN2)
      |-> (src_a == $past(edge_input_pin_2, 2) && src_a_valid))
      else $error("first channel pin route wrong");

   route_a_timer_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      (st_r.cfg.sel_a == EEIC_A_TIMER1)
      |-> (src_a == evt_in.timer_1_event))
      else $error("first channel timer route wrong");

   sticky_b_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      (flag_b && !wr_hi) [*2] |=> flag_b)
      else $error("second flag cleared without a write");

   cfg_write_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_lo |=> (st_r.cfg.pol_b == $past(wr_word.pol_b)
                 && st_r.cfg.mode_b == $past(wr_word.mode_b)))
      else $error("low byte write not stored");

   rdata_view_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      (setup_ph && addr_hit && !pwrite)
      |=> (prdata[9] == $past(flag_b) && prdata[8] == $past(flag_a)))
      else $error("readback does not show status flags");

   sticky_a_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      (flag_a && !wr_hi) [*2] |=> flag_a)
      else $error("first flag cleared without a write");

   level_mode_a_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      (!st_r.cfg.mode_a && src_a_valid && src_a == st_r.cfg.pol_a)
      |-> hit_a)
      else $error("first channel level mode missed a level");

   route_a_rsvd_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      (st_r.cfg.sel_a > EEIC_A_PIN1) |-> !hit_a)
      else $error("first channel reserved code fired");

   route_a_oc_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      (st_r.cfg.sel_a == EEIC_A_OC1)
      |-> (src_a == evt_in.output_compare_1 && src_a_valid))
      else $error("first channel compare route wrong");

   route_b_cmp_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      (st_r.cfg.sel_b == EEIC_B_COMPARATOR_2)
      |-> (src_b == evt_in.comparator_2 && src_b_valid))
      else $error("second channel comparator route wrong");

   route_b_oc_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      (st_r.cfg.sel_b == EEIC_B_OC1)
      |-> (src_b == evt_in.output_compare_1 && src_b_valid))
      else $error("second channel compare route wrong");

endmodule

// ### verif/eeic_src_model.sv
/*
 * Model of the on-chip event sources and the two edge input pins.
 * Assumes the bench commands source levels on the pclk rising edge.
 */
module eeic_src_model
   import eeic_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic [4:0] lvl,
   output eeic_evt_t       evt_in = '0,
   output logic            pin_1 = 1'b0,
   output logic            pin_2 = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   // Order: 0 timer, 1 compare, 2 comparator, 3 pin1, 4 pin2
   always @(posedge pclk) begin
      evt_in <= {lvl[0], lvl[1], lvl[2]};
      pin_1  <= lvl[3];
      pin_2  <= lvl[4];
   end
endmodule

// ### verif/test_edge_event_input_control.sv
/*
 * Self-checking bench for the edge event input control block.
 * Assumes the zero-wait APB slave and register layout of the package.
 */
module test_edge_event_input_control;
   import eeic_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic              pclk = 1'b0;
   logic              presetn = 1'b0;
   logic              psel = 1'b0;
   logic              penable = 1'b0;
   logic              pwrite = 1'b0;
   logic [EEIC_AW-1:0] paddr = '0;
   logic [EEIC_DW-1:0] pwdata = '0;
   logic [3:0]        pstrb = '0;
   logic [EEIC_DW-1:0] prdata;
   logic              pready;
   logic              pslverr;
   eeic_evt_t         evt_in;
   logic              pin_1;
   logic              pin_2;
   logic              flag_a;
   logic              flag_b;
   // Sources start high so the reset default low-active channel stays idle
   logic [4:0]        lvl = '1;
   int                err_count = 0;
   int                n_checks = 0;
   logic [31:0]       rd;
   logic              er;
   logic [15:0]       cfg;
   logic              pol;
   logic              mode;
   logic [1:0]        eh;
   int                seed;

   always #20 pclk = ~pclk;

   eeic_edge_ctrl i_eeic_edge_ctrl (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .evt_in(evt_in), .edge_input_pin_1(pin_1),
      .edge_input_pin_2(pin_2), .edge_a_occurred_flag(flag_a),
      .edge_b_occurred_flag(flag_b));
   eeic_src_model i_eeic_src_model (.pclk(pclk), .lvl(lvl),
      .evt_in(evt_in), .pin_1(pin_1), .pin_2(pin_2));

   // Source s feeds channel b (or a) when code c routes it
   function automatic logic hitf(logic b, int c, int s);
      if (b)
         return (c == 1 && s == 1) || (c == 2 && s == 3) || (c == 4 && s == 2);
      return (c == 0 && s == 0) || (c == 1 && s == 1) ||
             (c == 2 && s == 4) || (c == 3 && s == 3);
   endfunction

   task automatic summarize();
      if (err_count == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s exp %h got %h", what, exp, got);
      end
   endtask

   task automatic apb(logic w, logic [11:0] a, logic [31:0] d,
                      logic [3:0] s, output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      // No fixed latency assumed; only the watchdog ends a hung wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   initial begin
      repeat (40000) @(posedge pclk);
      err_count++;
      summarize();
   end

   initial begin
      seed = $urandom(32'ha3259635);
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h000, 32'h0000_0000, 4'h0, rd, er);
      chk("reset value", 32'h0000_0000, rd);
      apb(1'b1, 12'h004, 32'hFFFF_FFFF, 4'hF, rd, er);
      chk("unmapped wr err", 32'h0000_0001, {31'h0, er});
      apb(1'b0, 12'h004, 32'h0000_0000, 4'h0, rd, er);
      chk("unmapped rd", 32'h0000_0001, {rd[30:0], er});
      apb(1'b0, 12'h000, 32'h0000_0000, 4'h0, rd, er);
      chk("unmapped wr ignored", 32'h0000_0000, rd);
      for (int c = 0; c < 16; c++) begin
         for (int s = 0; s < 5; s++) begin
            pol = 1'($urandom);
            mode = 1'($urandom);
            lvl <= {5{~pol}};
            cfg = {mode, pol, 4'(c), 2'b00, mode, pol, 4'(c), 2'b00};
            eh = {hitf(1'b1, c, s), hitf(1'b0, c, s)};
            repeat (6) @(posedge pclk);
            apb(1'b1, 12'h000, {16'h0, cfg}, 4'h3, rd, er);
            chk("mapped wr err", 32'h0000_0000, {31'h0, er});
            // Old routing may set a flag while being replaced; clear it
            apb(1'b1, 12'h000, {16'h0, cfg}, 4'h2, rd, er);
            apb(1'b0, 12'h000, 32'h0000_0000, 4'h0, rd, er);
            chk("config", {16'h0, cfg}, rd);
            lvl[s] <= pol;
            repeat (6) @(posedge pclk);
            lvl[s] <= ~pol;
            repeat (6) @(posedge pclk);
            // Pulse gone; flag must hold
            chk("flags", {30'h0, eh}, {30'h0, flag_b, flag_a});
            apb(1'b0, 12'h000, 32'h0000_0000, 4'h0, rd, er);
            chk("status", {16'h0, cfg | {6'h0, eh, 8'h0}}, rd);
            lvl[s] <= pol;
            repeat (6) @(posedge pclk);
            apb(1'b1, 12'h000, {16'h0, cfg}, 4'h2, rd, er);
            repeat (4) @(posedge pclk);
            // Level mode re-sets at once, edge mode stays clear
            chk("clear", {30'h0, eh & {2{~mode}}},
                {30'h0, flag_b, flag_a});
         end
      end
      summarize();
   end
endmodule
